// file: logic/esc_pkg.sv
// constants, types and state layout of the eeprom security and setup block
// assumes one 40 MHz clock and an APB master on the same clock
//
// Behaviour
// - unprogrammed setup maps EEPROM at f800
// - setup upper nibble selects EEPROM base address
// - bootstrap mode reads setup byte as default
// - secured start in expanded/test/bootstrap erases EEPROM, RAM
// - secured part runs normally only in single-chip
// - both mode selects low means bootstrap
`default_nettype none

package esc_pkg;

   // =====================================================================
   // register map: printed offsets are indices, byte address is four times
   localparam logic [13:0] IDX_BLOCK_PROTECT = 14'h1035;
   localparam logic [13:0] IDX_SETUP_BYTE = 14'h103f;
   localparam logic [13:0] IDX_CONTROL = 14'h1040;
   localparam logic [13:0] IDX_STATUS = 14'h1041;
   localparam logic [15:0] ADDR_BLOCK_PROTECT = {IDX_BLOCK_PROTECT, 2'b00};
   localparam logic [15:0] ADDR_SETUP_BYTE = {IDX_SETUP_BYTE, 2'b00};
   localparam logic [15:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
   localparam logic [15:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

   // =====================================================================
   // reset values and field positions
   localparam logic [7:0] BLOCK_PROTECT_RESET = 8'h1f;
   localparam logic [7:0] SETUP_ERASED = 8'hff;
   localparam logic [7:0] SETUP_FORCED = 8'hff;
   localparam int SECURITY_DISABLE_BIT = 3;
   localparam logic [11:0] EEPROM_BASE_LOW = 12'h800;
   localparam int CTRL_RESTART_BIT = 0;
   localparam int CTRL_BULK_ERASE_BIT = 1;
   localparam logic [1:0] RESTART_COUNT = 2'h3;

   // =====================================================================
   // operating modes as {mode_select_b, mode_select_a}
   typedef enum logic [1:0] {
      MODE_BOOTSTRAP = 2'b00,
      MODE_TEST = 2'b01,
      MODE_SINGLE = 2'b10,
      MODE_EXPANDED = 2'b11
   } esc_mode_t;

   typedef enum logic [1:0] {
      ST_START = 2'b00,
      ST_CHECK = 2'b01,
      ST_ERASE = 2'b11,
      ST_RUN = 2'b10
   } esc_state_t;

   typedef struct packed {
      logic mode_a_meta;
      logic mode_a_sync;
      logic mode_b_meta;
      logic mode_b_sync;
      logic [1:0] restart_cnt;
      esc_state_t state;
      esc_mode_t mode;
      logic [7:0] block_protect;
      logic [7:0] setup_nv;
      logic [7:0] setup_active;
      logic erase_req;
      logic [31:0] rdata;
      logic err;
   } esc_state_s_t;

endpackage

`default_nettype wire

// file: logic/esc_top.sv
// eeprom protection, setup byte, mode capture and secure-start erase
// assumes APB master on pclk; mode pins asynchronous; erase_done from pclk logic
`default_nettype none

module esc_top
   import esc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mode_select_a,
   input wire logic mode_select_b,
   input wire logic erase_done,
   output logic erase_req,
   output logic [15:0] eeprom_base,
   output logic security_on,
   output logic eeprom_program_enable,
   output logic [1:0] op_mode,
   output logic running
);

   esc_state_s_t st_q;
   esc_state_s_t st_d;
   logic setup_phase;
   logic access_phase;
   logic hit;
   logic secured_now;

   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;
   assign hit = (paddr == ADDR_BLOCK_PROTECT) || (paddr == ADDR_SETUP_BYTE)
      || (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS);
   assign secured_now = !st_q.setup_active[SECURITY_DISABLE_BIT];

   // =====================================================================
   // next state
   always_comb begin
      st_d = st_q;
      st_d.mode_a_meta = mode_select_a;
      st_d.mode_a_sync = st_q.mode_a_meta;
      st_d.mode_b_meta = mode_select_b;
      st_d.mode_b_sync = st_q.mode_b_meta;

      // read data captured in setup phase
      if (setup_phase) begin
         st_d.err = !hit;
         st_d.rdata = 32'h0000_0000;
         case (paddr)
            ADDR_BLOCK_PROTECT: st_d.rdata[7:0] = st_q.block_protect;
            ADDR_SETUP_BYTE: st_d.rdata[7:0] = (st_q.mode == MODE_BOOTSTRAP) ?
               SETUP_FORCED : st_q.setup_nv;
            ADDR_STATUS: st_d.rdata[5:0] = {st_q.erase_req, secured_now,
               st_q.state, st_q.mode};
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end

      if (access_phase && pwrite) begin
         case (paddr)
            ADDR_BLOCK_PROTECT: st_d.block_protect = pwdata[7:0];
            ADDR_SETUP_BYTE: begin
               if (st_q.block_protect == 8'h00) begin
                  st_d.setup_nv = st_q.setup_nv & pwdata[7:0];
               end
            end
            ADDR_CONTROL: begin
               if (pwdata[CTRL_BULK_ERASE_BIT] && st_q.block_protect == 8'h00) begin
                  st_d.setup_nv = SETUP_ERASED;
               end
               if (pwdata[CTRL_RESTART_BIT] && st_q.state == ST_RUN) begin
                  st_d.state = ST_START;
                  st_d.restart_cnt = RESTART_COUNT;
               end
            end
            default: st_d.err = st_q.err;
         endcase
      end

      case (st_q.state)
         ST_START: begin
            if (st_q.restart_cnt != 2'h0) begin
               st_d.restart_cnt = st_q.restart_cnt - 2'h1;
            end else begin
               // modes and setup taken at restart
               st_d.mode = esc_mode_t'({st_q.mode_b_sync, st_q.mode_a_sync});
               st_d.setup_active = st_q.setup_nv;
               st_d.state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (secured_now && st_q.mode != MODE_SINGLE) begin
               st_d.state = ST_ERASE;
               st_d.erase_req = 1'b1;
            end else begin
               st_d.state = ST_RUN;
            end
         end
         ST_ERASE: begin
            if (erase_done) begin
               st_d.erase_req = 1'b0;
               st_d.state = ST_RUN;
            end
         end
         ST_RUN: st_d.erase_req = 1'b0;
         default: st_d.state = ST_START;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '{mode_a_meta: 1'b0, mode_a_sync: 1'b0, mode_b_meta: 1'b0,
            mode_b_sync: 1'b0, restart_cnt: RESTART_COUNT, state: ST_START,
            mode: MODE_SINGLE, block_protect: BLOCK_PROTECT_RESET,
            setup_nv: SETUP_ERASED, setup_active: SETUP_ERASED, erase_req: 1'b0,
            rdata: 32'h0000_0000, err: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   // =====================================================================
   // outputs
   assign prdata = st_q.rdata;
   assign pready = 1'b1;
   assign pslverr = access_phase && st_q.err;
   assign erase_req = st_q.erase_req;
   assign eeprom_base = {st_q.setup_active[7:4], EEPROM_BASE_LOW};
   assign security_on = secured_now;
   assign eeprom_program_enable = (st_q.block_protect == 8'h00);
   assign op_mode = st_q.mode;
   assign running = (st_q.state == ST_RUN);

   // =====================================================================
   // checks
   sequence s_secured_check;
      st_q.state == ST_CHECK && secured_now && st_q.mode != MODE_SINGLE;
   endsequence

   sequence s_erase_phase;
      erase_req && !running;
   endsequence

   property p_default_base;
      @(posedge pclk) disable iff (!presetn)
      st_q.setup_active == SETUP_ERASED |-> eeprom_base == 16'hf800;
   endproperty
   a_default_base: assert property (p_default_base) else $error("default base wrong");

   property p_nibble_base;
      @(posedge pclk) disable iff (!presetn)
      st_q.state == ST_CHECK |-> eeprom_base[15:12] == $past(st_q.setup_nv[7:4], 1);
   endproperty
   a_nibble_base: assert property (p_nibble_base) else $error("base not from nibble");

   property p_value_05;
      @(posedge pclk) disable iff (!presetn)
      st_q.setup_active == 8'h05 |-> security_on && eeprom_base == 16'h0800;
   endproperty
   a_value_05: assert property (p_value_05) else $error("value 05 mapping wrong");

   property p_boot_read;
      @(posedge pclk) disable iff (!presetn)
      setup_phase && !pwrite && paddr == ADDR_SETUP_BYTE && op_mode == MODE_BOOTSTRAP
      |=> prdata[7:0] == SETUP_FORCED;
   endproperty
   a_boot_read: assert property (p_boot_read) else $error("boot read not forced");

   property p_secure_erase;
      @(posedge pclk) disable iff (!presetn)
      s_secured_check |=> s_erase_phase;
   endproperty
   a_secure_erase: assert property (p_secure_erase) else $error("no secure erase");

   property p_single_runs;
      @(posedge pclk) disable iff (!presetn)
      st_q.state == ST_CHECK && op_mode == MODE_SINGLE |=> running && !erase_req;
   endproperty
   a_single_runs: assert property (p_single_runs) else $error("single-chip blocked");

   property p_boot_mode;
      @(posedge pclk) disable iff (!presetn)
      st_q.state == ST_START && st_q.restart_cnt == 2'h0 && !st_q.mode_a_sync
      && !st_q.mode_b_sync |=> op_mode == MODE_BOOTSTRAP ##1 st_q.state != ST_START;
   endproperty
   a_boot_mode: assert property (p_boot_mode) else $error("bootstrap not entered");

   property p_deferred;
      @(posedge pclk) disable iff (!presetn)
      access_phase && pwrite && paddr == ADDR_SETUP_BYTE && running
      |=> $stable(eeprom_base) && $stable(security_on);
   endproperty
   a_deferred: assert property (p_deferred) else $error("setup acted at once");

   property p_protect_blocks;
      @(posedge pclk) disable iff (!presetn)
      access_phase && pwrite && paddr == ADDR_SETUP_BYTE && !eeprom_program_enable
      |=> $stable(st_q.setup_nv);
   endproperty
   a_protect_blocks: assert property (p_protect_blocks) else $error("protected write");

   property p_erase_held;
      @(posedge pclk) disable iff (!presetn)
      st_q.state == ST_ERASE && !erase_done |=> erase_req && !running;
   endproperty
   a_erase_held: assert property (p_erase_held) else $error("erase dropped early");

   property p_single_no_erase;
      @(posedge pclk) disable iff (!presetn)
      op_mode == MODE_SINGLE |-> !erase_req;
   endproperty
   a_single_no_erase: assert property (p_single_no_erase) else $error("single erased");

endmodule // esc_top

`default_nettype wire

// file: testbench/esc_top_bench.sv
// bench for the eeprom security and setup block: apb tasks, queued read checks
// assumes esc_pkg register map; mode pins driven directly by the bench
`default_nettype none

module esc_top_bench;
   import esc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, mode_select_a = 0, mode_select_b = 1, erase_done = 0;
   logic erase_req, security_on, eeprom_program_enable, running;
   logic [15:0] eeprom_base;
   logic [1:0] op_mode;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   int mismatches = 0, comparisons = 0, seed = 67, n;
   logic [7:0] r;
   logic [1:0] modes[3] = '{2'b11, 2'b01, 2'b00};
   esc_top i_esc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mode_select_a(mode_select_a), .mode_select_b(mode_select_b),
      .erase_done(erase_done), .erase_req(erase_req), .eeprom_base(eeprom_base),
      .security_on(security_on), .eeprom_program_enable(eeprom_program_enable),
      .op_mode(op_mode), .running(running));
   always #12.5 pclk = ~pclk;
   // ==========================================================
   // checking and closing
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // exp: {compare data, expected error, expected data}
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [33:0] exp);
      exp_q.push_back(exp);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      for (n = 0; pready !== 1'b1 && n < 50; n++) @(posedge pclk);
      if (n == 50) begin
         $display("ERROR pready expected 1 seen timeout");
         mismatches++;
         results();
      end
      psel <= 0;
      penable <= 0;
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (exp_q.size() == 0) check("queue", 32'(exp_q.size()), 32'h1);
         else begin
            e = exp_q.pop_front();
            check("pslverr", 32'(pslverr), 32'(e[32]));
            if (e[33]) check("prdata", prdata, e[31:0]);
         end
      end
   end
   task automatic wait_run(input bit any);
      for (n = 0; n < 40 && !(running === 1'b1 || (any && erase_req === 1'b1)); n++)
         @(posedge pclk);
      if (n == 40) begin
         $display("ERROR running expected 1 seen timeout");
         mismatches++;
         results();
      end
   endtask
   task automatic restart();
      apb(1, ADDR_CONTROL, 32'h1, 34'h0);
      repeat (2) @(posedge pclk);
      wait_run(1);
      @(negedge pclk);
   endtask
   initial begin
      #(25 * 20000);
      $display("ERROR run_time expected end seen timeout");
      mismatches++;
      results();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      wait_run(0);
      @(negedge pclk);
      check("eeprom_base", 32'(eeprom_base), 32'h0000f800);
      check("security_on", 32'(security_on), 32'h0);
      check("op_mode", 32'(op_mode), 32'h2);
      check("program_enable", 32'(eeprom_program_enable), 32'h0);
      apb(0, ADDR_BLOCK_PROTECT, 32'h0, {2'b10, 32'h1f});
      apb(0, ADDR_SETUP_BYTE, 32'h0, {2'b10, 32'hff});
      apb(1, ADDR_SETUP_BYTE, 32'h5, 34'h0);
      apb(0, ADDR_SETUP_BYTE, 32'h0, {2'b10, 32'hff});
      r = 8'($random(seed));
      apb(1, ADDR_BLOCK_PROTECT, {24'h0, r}, 34'h0);
      apb(0, ADDR_BLOCK_PROTECT, 32'h0, {2'b10, 24'h0, r});
      apb(1, ADDR_BLOCK_PROTECT, 32'h0, 34'h0);
      repeat (2) @(negedge pclk);
      check("program_enable", 32'(eeprom_program_enable), 32'h1);
      apb(1, ADDR_CONTROL, 32'h2, 34'h0);
      apb(1, ADDR_SETUP_BYTE, 32'h5, 34'h0);
      apb(0, ADDR_SETUP_BYTE, 32'h0, {2'b10, 32'h05});
      apb(0, 16'h0000, 32'h0, {2'b01, 32'h0});
      @(negedge pclk);
      check("eeprom_base", 32'(eeprom_base), 32'h0000f800);
      check("security_on", 32'(security_on), 32'h0);
      restart();
      check("eeprom_base", 32'(eeprom_base), 32'h00000800);
      check("security_on", 32'(security_on), 32'h1);
      check("running", 32'(running), 32'h1);
      check("erase_req", 32'(erase_req), 32'h0);
      foreach (modes[i]) begin
         @(posedge pclk);
         {mode_select_b, mode_select_a} <= modes[i];
         restart();
         check("erase_req", 32'(erase_req), 32'h1);
         check("op_mode", 32'(op_mode), 32'(modes[i]));
         if (modes[i] == 2'b00) apb(0, ADDR_SETUP_BYTE, 32'h0, {2'b10, 32'hff});
         if (modes[i] == 2'b11) apb(0, ADDR_STATUS, 32'h0,
            {2'b10, 26'h0, 2'b11, ST_ERASE, MODE_EXPANDED});
         @(posedge pclk);
         erase_done <= 1;
         wait_run(0);
         erase_done <= 0;
      end
      {mode_select_b, mode_select_a} <= 2'b10;
      restart();
      check("running", 32'(running), 32'h1);
      apb(0, ADDR_SETUP_BYTE, 32'h0, {2'b10, 32'h05});
      apb(0, ADDR_STATUS, 32'h0, {2'b10, 26'h0, 2'b01, ST_RUN, MODE_SINGLE});
      @(posedge pclk);
      check("queue", 32'(exp_q.size()), 32'h0);
      results();
   end
endmodule // esc_top_bench

`default_nettype wire
